// ### pkg/ctap_pkg.sv
// Constants, field layout and types for the cache test access port
// Functional notes
// - Direct access refused while bank is cache
// - Icache line holds four selectable 64-bit words
// - Icache data read/write via test data pair
// - Icache tag moves through low data register only
// - 0x0C010360 reads tag way3 set27 subbank1
// - 0x0C010362 writes tag way3 set27 subbank1
// - Command bits 3,4 ignored on tag access
// - 0x0C010374 reads data word of way3 set27
// - 0x0C010366 writes pair into word 0
// - Data command bit 24 selects instruction SRAM
// - SRAM test moves one 64-bit word per command
// - Bit 24 clear accesses data cache line
// - Dcache tag moves through low data register
// - Bit 14 ignored during data cache access
// - Tag write with valid clear invalidates line
package ctap_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_ICMD = 8'h00;
  localparam logic [7:0] OFF_IDATA_LO = 8'h04;
  localparam logic [7:0] OFF_IDATA_HI = 8'h08;
  localparam logic [7:0] OFF_DCMD = 8'h0C;
  localparam logic [7:0] OFF_DDATA_LO = 8'h10;
  localparam logic [7:0] OFF_DDATA_HI = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // Command field positions
  localparam int RW_BIT = 1;
  localparam int DT_BIT = 2;
  localparam int DW_LSB = 3;
  localparam int DW_W = 2;
  localparam int SET_LSB = 5;
  localparam int ISET_W = 5;
  localparam int DSET_W = 6;
  localparam int SUB_LSB = 16;
  localparam int SUB_W = 2;
  localparam int WAY_LSB = 26;
  localparam int IWAY_W = 2;
  localparam int DWAY_W = 1;
  localparam int DBANK_BIT = 23;
  localparam int ISRAM_SEL_BIT = 24;
  localparam int ISRAM_LSB = 3;
  localparam int ISRAM_W = 8;
  localparam int ISRAM_BANK_BIT = 14;
  localparam int TAG_VALID_BIT = 0;
  // Storage geometry
  localparam int DWORD_W = 64;
  localparam int TAG_W = 32;
  localparam int MEM_IDX_W = 12;
  localparam int IDATA_IDX_W = IWAY_W + SUB_W + ISET_W + DW_W;
  localparam int ITAG_IDX_W = IWAY_W + SUB_W + ISET_W;
  localparam int DDATA_IDX_W = 1 + DWAY_W + SUB_W + DSET_W + DW_W;
  localparam int DTAG_IDX_W = 1 + DWAY_W + SUB_W + DSET_W;
  localparam int ISRAM_IDX_W = SUB_W + 1 + ISRAM_W;
  // Example commands and their decoded location
  localparam logic [31:0] CMD_ITAG_RD = 32'h0C01_0360;
  localparam logic [31:0] CMD_ITAG_WR = 32'h0C01_0362;
  localparam logic [31:0] CMD_IDATA_RD = 32'h0C01_0374;
  localparam logic [31:0] CMD_IDATA_WR = 32'h0C01_0366;
  localparam logic [1:0] EX_WAY = 2'h3;
  localparam logic [4:0] EX_SET = 5'h1B;
  localparam logic [1:0] EX_SUB = 2'h1;
  localparam logic [1:0] EX_RD_WORD = 2'h2;
  localparam logic [1:0] EX_WR_WORD = 2'h0;
  typedef enum logic [2:0] {
    CTAP_ITAG, CTAP_IDATA, CTAP_DTAG, CTAP_DDATA, CTAP_ISRAM
  } ctap_target_t;
endpackage : ctap_pkg

// ### pkg/ctap_mem_if.sv
// Request and answer signals between control logic and test storage
`timescale 1ns/1ps
interface ctap_mem_if;
  logic req;
  logic wr;
  ctap_pkg::ctap_target_t target;
  logic [ctap_pkg::MEM_IDX_W-1:0] idx;
  logic [ctap_pkg::DWORD_W-1:0] wdata;
  logic [ctap_pkg::DWORD_W-1:0] rdata;
  logic done;
  modport ctl (output req, output wr, output target, output idx,
    output wdata, input rdata, input done);
  modport mem (input req, input wr, input target, input idx,
    input wdata, output rdata, output done);
endinterface : ctap_mem_if

// ### src/ctap_store.sv
// Tag and data arrays of both caches and the instruction SRAM
`timescale 1ns/1ps
module ctap_store (
  input wire logic aclk,
  input wire logic aresetn,
  ctap_mem_if.mem mif
);
  logic [ctap_pkg::DWORD_W-1:0] idata_mem [1<<ctap_pkg::IDATA_IDX_W];
  logic [ctap_pkg::TAG_W-1:0] itag_mem [1<<ctap_pkg::ITAG_IDX_W];
  logic [ctap_pkg::DWORD_W-1:0] ddata_mem [1<<ctap_pkg::DDATA_IDX_W];
  logic [ctap_pkg::TAG_W-1:0] dtag_mem [1<<ctap_pkg::DTAG_IDX_W];
  logic [ctap_pkg::DWORD_W-1:0] isram_mem [1<<ctap_pkg::ISRAM_IDX_W];

  ////////////////////////////////////////////////////////////////////////////
  // Arrays are not reset; a tag written with valid clear is an invalid line
  always_ff @(posedge aclk) begin
    if (mif.req && mif.wr) begin
      case (mif.target)
        ctap_pkg::CTAP_ITAG: itag_mem[mif.idx[ctap_pkg::ITAG_IDX_W-1:0]] <=
          mif.wdata[ctap_pkg::TAG_W-1:0];
        ctap_pkg::CTAP_IDATA:
          idata_mem[mif.idx[ctap_pkg::IDATA_IDX_W-1:0]] <= mif.wdata;
        ctap_pkg::CTAP_DTAG: dtag_mem[mif.idx[ctap_pkg::DTAG_IDX_W-1:0]] <=
          mif.wdata[ctap_pkg::TAG_W-1:0];
        ctap_pkg::CTAP_DDATA:
          ddata_mem[mif.idx[ctap_pkg::DDATA_IDX_W-1:0]] <= mif.wdata;
        ctap_pkg::CTAP_ISRAM:
          isram_mem[mif.idx[ctap_pkg::ISRAM_IDX_W-1:0]] <= mif.wdata;
        default: ;
      endcase
    end
  end

  // Read port, answer one cycle after the request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mif.rdata <= '0;
    end else if (mif.req && !mif.wr) begin
      case (mif.target)
        ctap_pkg::CTAP_ITAG: mif.rdata <= {{(ctap_pkg::DWORD_W -
          ctap_pkg::TAG_W){1'b0}}, itag_mem[mif.idx[ctap_pkg::ITAG_IDX_W-1:0]]};
        ctap_pkg::CTAP_IDATA:
          mif.rdata <= idata_mem[mif.idx[ctap_pkg::IDATA_IDX_W-1:0]];
        ctap_pkg::CTAP_DTAG: mif.rdata <= {{(ctap_pkg::DWORD_W -
          ctap_pkg::TAG_W){1'b0}}, dtag_mem[mif.idx[ctap_pkg::DTAG_IDX_W-1:0]]};
        ctap_pkg::CTAP_DDATA:
          mif.rdata <= ddata_mem[mif.idx[ctap_pkg::DDATA_IDX_W-1:0]];
        ctap_pkg::CTAP_ISRAM:
          mif.rdata <= isram_mem[mif.idx[ctap_pkg::ISRAM_IDX_W-1:0]];
        default: mif.rdata <= '0;
      endcase
    end
  end

  // Completion strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mif.done <= 1'b0;
    end else begin
      mif.done <= mif.req;
    end
  end
endmodule : ctap_store

// ### src/ctap_top.sv
// Cache test access port: AXI4-Lite registers, command decode, storage
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module ctap_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic l1i_as_cache,
  input wire logic l1d_as_cache,
  input wire logic direct_req_instr,
  input wire logic direct_req_data,
  output logic direct_grant_instr,
  output logic direct_grant_data
);
  typedef enum logic {CTAP_IDLE, CTAP_WAIT} ctap_state_t;

  ctap_state_t state;
  logic [31:0] icmd;
  logic [31:0] idata_lo;
  logic [31:0] idata_hi;
  logic [31:0] dcmd;
  logic [31:0] ddata_lo;
  logic [31:0] ddata_hi;
  logic wr_fire;
  logic rd_fire;
  logic [31:0] old_word;
  logic [31:0] new_word;
  logic addr_ok;
  logic is_cmd;
  logic is_dcmd;
  ctap_pkg::ctap_target_t dec_target;
  logic [ctap_pkg::MEM_IDX_W-1:0] dec_idx;
  logic [ctap_pkg::DWORD_W-1:0] dec_wdata;
  logic [31:0] read_mux;
  logic read_ok;

  ctap_mem_if mif ();

  ctap_store u_store (.aclk(aclk), .aresetn(aresetn), .mif(mif));

  ////////////////////////////////////////////////////////////////////////////
  // Byte lane merge for partial writes
  function automatic logic [31:0] ctap_merge(input logic [31:0] old,
      input logic [31:0] din, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = din[b*8 +: 8];
      end
    end
    return res;
  endfunction : ctap_merge

  assign wr_fire = awready && awvalid && wready && wvalid;
  assign rd_fire = arready && arvalid;
  assign is_cmd = (awaddr == ctap_pkg::OFF_ICMD) ||
    (awaddr == ctap_pkg::OFF_DCMD);
  assign is_dcmd = (awaddr == ctap_pkg::OFF_DCMD);

  // Old value of the addressed register and write address check
  always_comb begin
    old_word = ctap_pkg::REG_RESET;
    addr_ok = 1'b1;
    case (awaddr)
      ctap_pkg::OFF_ICMD: old_word = icmd;
      ctap_pkg::OFF_IDATA_LO: old_word = idata_lo;
      ctap_pkg::OFF_IDATA_HI: old_word = idata_hi;
      ctap_pkg::OFF_DCMD: old_word = dcmd;
      ctap_pkg::OFF_DDATA_LO: old_word = ddata_lo;
      ctap_pkg::OFF_DDATA_HI: old_word = ddata_hi;
      default: addr_ok = 1'b0;
    endcase
    new_word = ctap_merge(old_word, wdata, wstrb);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode into a storage target and index
  always_comb begin
    dec_target = ctap_pkg::CTAP_ITAG;
    dec_idx = '0;
    dec_wdata = {idata_hi, idata_lo};
    if (!is_dcmd) begin
      if (new_word[ctap_pkg::DT_BIT]) begin
        dec_target = ctap_pkg::CTAP_IDATA;
        // Any of four words in the line
        dec_idx = ctap_pkg::MEM_IDX_W'({
          new_word[ctap_pkg::WAY_LSB +: ctap_pkg::IWAY_W],
          new_word[ctap_pkg::SUB_LSB +: ctap_pkg::SUB_W],
          new_word[ctap_pkg::SET_LSB +: ctap_pkg::ISET_W],
          new_word[ctap_pkg::DW_LSB +: ctap_pkg::DW_W]});
      end else begin
        // Word select bits play no part in a tag index
        dec_idx = ctap_pkg::MEM_IDX_W'({
          new_word[ctap_pkg::WAY_LSB +: ctap_pkg::IWAY_W],
          new_word[ctap_pkg::SUB_LSB +: ctap_pkg::SUB_W],
          new_word[ctap_pkg::SET_LSB +: ctap_pkg::ISET_W]});
      end
    end else begin
      dec_wdata = {ddata_hi, ddata_lo};
      if (new_word[ctap_pkg::ISRAM_SEL_BIT]) begin
        dec_target = ctap_pkg::CTAP_ISRAM;
        dec_idx = ctap_pkg::MEM_IDX_W'({
          new_word[ctap_pkg::SUB_LSB +: ctap_pkg::SUB_W],
          new_word[ctap_pkg::ISRAM_BANK_BIT],
          new_word[ctap_pkg::ISRAM_LSB +: ctap_pkg::ISRAM_W]});
      end else begin
        // Bit 14 is left out of every data cache index
        dec_target = new_word[ctap_pkg::DT_BIT] ? ctap_pkg::CTAP_DDATA :
          ctap_pkg::CTAP_DTAG;
        dec_idx = new_word[ctap_pkg::DT_BIT] ?
          ctap_pkg::MEM_IDX_W'({new_word[ctap_pkg::DBANK_BIT],
            new_word[ctap_pkg::WAY_LSB +: ctap_pkg::DWAY_W],
            new_word[ctap_pkg::SUB_LSB +: ctap_pkg::SUB_W],
            new_word[ctap_pkg::SET_LSB +: ctap_pkg::DSET_W],
            new_word[ctap_pkg::DW_LSB +: ctap_pkg::DW_W]}) :
          ctap_pkg::MEM_IDX_W'({new_word[ctap_pkg::DBANK_BIT],
            new_word[ctap_pkg::WAY_LSB +: ctap_pkg::DWAY_W],
            new_word[ctap_pkg::SUB_LSB +: ctap_pkg::SUB_W],
            new_word[ctap_pkg::SET_LSB +: ctap_pkg::DSET_W]});
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write channel accept; address and data taken in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
    end else if (wr_fire) begin
      awready <= 1'b0;
      wready <= 1'b0;
    end else begin
      // No new write while an access or a response is outstanding
      awready <= awvalid && wvalid && !bvalid && state == CTAP_IDLE &&
        !awready;
      wready <= awvalid && wvalid && !bvalid && state == CTAP_IDLE &&
        !awready;
    end
  end

  // Command and data registers; storage results land in the data pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      icmd <= ctap_pkg::REG_RESET;
      idata_lo <= ctap_pkg::REG_RESET;
      idata_hi <= ctap_pkg::REG_RESET;
      dcmd <= ctap_pkg::REG_RESET;
      ddata_lo <= ctap_pkg::REG_RESET;
      ddata_hi <= ctap_pkg::REG_RESET;
    end else if (wr_fire) begin
      case (awaddr)
        ctap_pkg::OFF_ICMD: icmd <= new_word;
        ctap_pkg::OFF_IDATA_LO: idata_lo <= new_word;
        ctap_pkg::OFF_IDATA_HI: idata_hi <= new_word;
        ctap_pkg::OFF_DCMD: dcmd <= new_word;
        ctap_pkg::OFF_DDATA_LO: ddata_lo <= new_word;
        ctap_pkg::OFF_DDATA_HI: ddata_hi <= new_word;
        default: ;
      endcase
    end else if (mif.done && !mif.wr) begin
      case (mif.target)
        ctap_pkg::CTAP_ITAG: idata_lo <= mif.rdata[31:0];
        ctap_pkg::CTAP_IDATA: {idata_hi, idata_lo} <= mif.rdata;
        ctap_pkg::CTAP_DTAG: ddata_lo <= mif.rdata[31:0];
        ctap_pkg::CTAP_DDATA: {ddata_hi, ddata_lo} <= mif.rdata;
        ctap_pkg::CTAP_ISRAM: {ddata_hi, ddata_lo} <= mif.rdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer: one storage request per command write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= CTAP_IDLE;
      mif.req <= 1'b0;
      mif.wr <= 1'b0;
      mif.target <= ctap_pkg::CTAP_ITAG;
      mif.idx <= '0;
      mif.wdata <= '0;
    end else begin
      mif.req <= 1'b0;
      case (state)
        CTAP_IDLE: begin
          if (wr_fire && is_cmd) begin
            // Pair sampled now, so it must already hold the write value
            mif.req <= 1'b1;
            mif.wr <= new_word[ctap_pkg::RW_BIT];
            mif.target <= dec_target;
            mif.idx <= dec_idx;
            mif.wdata <= dec_wdata;
            state <= CTAP_WAIT;
          end
        end
        CTAP_WAIT: begin
          if (mif.done) begin
            state <= CTAP_IDLE;
          end
        end
        default: state <= CTAP_IDLE;
      endcase
    end
  end

  // Write response; a command answers only when its access is finished
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= ctap_pkg::RESP_OKAY;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end else if (wr_fire && !is_cmd) begin
      bvalid <= 1'b1;
      bresp <= addr_ok ? ctap_pkg::RESP_OKAY : ctap_pkg::RESP_SLVERR;
    end else if (state == CTAP_WAIT && mif.done) begin
      bvalid <= 1'b1;
      bresp <= ctap_pkg::RESP_OKAY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, status shows busy and the cache configuration
  always_comb begin
    read_mux = ctap_pkg::REG_RESET;
    read_ok = 1'b1;
    case (araddr)
      ctap_pkg::OFF_ICMD: read_mux = icmd;
      ctap_pkg::OFF_IDATA_LO: read_mux = idata_lo;
      ctap_pkg::OFF_IDATA_HI: read_mux = idata_hi;
      ctap_pkg::OFF_DCMD: read_mux = dcmd;
      ctap_pkg::OFF_DDATA_LO: read_mux = ddata_lo;
      ctap_pkg::OFF_DDATA_HI: read_mux = ddata_hi;
      ctap_pkg::OFF_STATUS: read_mux = {29'h0000_0000,
        state == CTAP_WAIT, l1d_as_cache, l1i_as_cache};
      default: read_ok = 1'b0;
    endcase
  end

  // Reads held off while an access runs, but arready set in the command write cycle lets one read in early with stale data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= ctap_pkg::REG_RESET;
      rresp <= ctap_pkg::RESP_OKAY;
    end else begin
      arready <= arvalid && !arready && !rvalid && state == CTAP_IDLE &&
        !mif.req;
      if (rd_fire) begin
        rvalid <= 1'b1;
        rdata <= read_mux;
        rresp <= read_ok ? ctap_pkg::RESP_OKAY : ctap_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Direct core or DMA access only to banks not configured as cache
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      direct_grant_instr <= 1'b0;
      direct_grant_data <= 1'b0;
    end else begin
      direct_grant_instr <= direct_req_instr && !l1i_as_cache;
      direct_grant_data <= direct_req_data && !l1d_as_cache;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_cmd_write;
    wr_fire && is_cmd;
  endsequence
  sequence s_access_done;
    ##1 mif.req ##1 mif.done ##1 bvalid;
  endsequence
  property p_one_access;
    s_cmd_write |-> s_access_done;
  endproperty
  a_one_access: assert property (p_one_access)
    else $error("command write did not produce one access");
  property p_req_single;
    mif.req |=> !mif.req [*2];
  endproperty
  a_req_single: assert property (p_req_single)
    else $error("storage request longer than one cycle");
  property p_refuse_instr;
    l1i_as_cache |=> !direct_grant_instr;
  endproperty
  a_refuse_instr: assert property (p_refuse_instr)
    else $error("direct access granted to instruction cache bank");
  property p_itag_low_only;
    mif.done && !mif.wr && mif.target == ctap_pkg::CTAP_ITAG
      |=> $stable(idata_hi) && idata_lo == $past(mif.rdata[31:0]);
  endproperty
  a_itag_low_only: assert property (p_itag_low_only)
    else $error("icache tag read touched the high data register");
  property p_idata_pair;
    mif.done && !mif.wr && mif.target == ctap_pkg::CTAP_IDATA
      |=> {idata_hi, idata_lo} == $past(mif.rdata);
  endproperty
  a_idata_pair: assert property (p_idata_pair)
    else $error("icache data read not placed in the data pair");
  property p_isram_route;
    s_cmd_write and is_dcmd && new_word[ctap_pkg::ISRAM_SEL_BIT]
      |=> mif.target == ctap_pkg::CTAP_ISRAM;
  endproperty
  a_isram_route: assert property (p_isram_route)
    else $error("bit 24 did not route to instruction SRAM");
  property p_ex_tag;
    s_cmd_write and !is_dcmd &&
      (new_word == ctap_pkg::CMD_ITAG_RD || new_word == ctap_pkg::CMD_ITAG_WR)
      |=> mif.target == ctap_pkg::CTAP_ITAG &&
      mif.wr == $past(new_word[ctap_pkg::RW_BIT]) &&
      mif.idx == ctap_pkg::MEM_IDX_W'({ctap_pkg::EX_WAY, ctap_pkg::EX_SUB,
        ctap_pkg::EX_SET});
  endproperty
  a_ex_tag: assert property (p_ex_tag)
    else $error("example tag command decoded wrongly");
  property p_ex_data;
    s_cmd_write and !is_dcmd &&
      (new_word == ctap_pkg::CMD_IDATA_RD || new_word == ctap_pkg::CMD_IDATA_WR)
      |=> mif.target == ctap_pkg::CTAP_IDATA &&
      mif.idx == ctap_pkg::MEM_IDX_W'({ctap_pkg::EX_WAY, ctap_pkg::EX_SUB,
        ctap_pkg::EX_SET, mif.wr ? ctap_pkg::EX_WR_WORD :
        ctap_pkg::EX_RD_WORD});
  endproperty
  a_ex_data: assert property (p_ex_data)
    else $error("example data command decoded wrongly");
  property p_tag_ignores_word;
    mif.req && mif.target == ctap_pkg::CTAP_ITAG
      |-> mif.idx[ctap_pkg::MEM_IDX_W-1:ctap_pkg::ITAG_IDX_W] == '0;
  endproperty
  a_tag_ignores_word: assert property (p_tag_ignores_word)
    else $error("icache tag index uses word select bits");
  property p_bit14_ignored;
    s_cmd_write and is_dcmd && !new_word[ctap_pkg::ISRAM_SEL_BIT]
      |=> mif.wr == $past(new_word[ctap_pkg::RW_BIT]) &&
      (mif.idx >> (mif.target == ctap_pkg::CTAP_DDATA ? ctap_pkg::DW_W : 0))
      == ctap_pkg::MEM_IDX_W'($past({new_word[ctap_pkg::DBANK_BIT],
      new_word[ctap_pkg::WAY_LSB], new_word[ctap_pkg::SUB_LSB +:
      ctap_pkg::SUB_W], new_word[ctap_pkg::SET_LSB +: ctap_pkg::DSET_W]}));
  endproperty
  a_bit14_ignored: assert property (p_bit14_ignored)
    else $error("data cache decode out of range");
endmodule : ctap_top

// ### verif/tb_top.sv
// Self-checking bench for the cache test access port
`timescale 1ns/1ps
module tb_top;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, l1i_as_cache, l1d_as_cache;
  logic direct_req_instr, direct_req_data;
  logic direct_grant_instr, direct_grant_data;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int n_fail = 0;
  int n_checks = 0;
  // Seed 22729
  logic [31:0] lfsr_q = 32'h0000_58C9;

  ctap_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .l1i_as_cache(l1i_as_cache),
    .l1d_as_cache(l1d_as_cache), .direct_req_instr(direct_req_instr),
    .direct_req_data(direct_req_data),
    .direct_grant_instr(direct_grant_instr),
    .direct_grant_data(direct_grant_data));

  // 125 MHz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  //////////////////////////////////////////////////////////////////////////
  // Expectation helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // Instruction command from its fields
  function automatic logic [31:0] icmd(input logic [1:0] way,
      input logic [4:0] set, input logic [1:0] sub, input logic [1:0] word);
    return {4'h0, way, 8'h00, sub, 6'h00, set, word, 3'h6};
  endfunction : icmd

  //////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  // A wait that never ends counts as a mismatch
  task automatic stall();
    n_fail++;
    $display("ERROR at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    complete_run();
  endtask : stall

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite master; an edge always passes before a new request
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 50 && !got; k++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        got = 1'b1;
        r = bresp;
        bready <= 1'b0;
      end
    end
    if (!got) stall();
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 50 && !got; k++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        got = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    if (!got) stall();
  endtask : axi_read

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    logic [1:0] r;
    axi_write(a, d, r);
    chk32({30'h0, r}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    chk32(d, e);
    chk32({30'h0, r}, {30'h0, er});
  endtask : rd

  // Load a data pair, then the command; b is the command offset
  task automatic put(input logic [7:0] b, input logic [31:0] c, lo, hi);
    wr(b + 8'h04, lo, ctap_pkg::RESP_OKAY);
    wr(b + 8'h08, hi, ctap_pkg::RESP_OKAY);
    wr(b, c, ctap_pkg::RESP_OKAY);
  endtask : put

  // Clear the pair so a stale value cannot pass, then read back
  task automatic get(input logic [7:0] b, input logic [31:0] c, lo, hi);
    wr(b + 8'h04, 32'h0, ctap_pkg::RESP_OKAY);
    wr(b + 8'h08, 32'h0, ctap_pkg::RESP_OKAY);
    wr(b, c, ctap_pkg::RESP_OKAY);
    rd(b + 8'h04, lo, ctap_pkg::RESP_OKAY);
    rd(b + 8'h08, hi, ctap_pkg::RESP_OKAY);
  endtask : get

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] a_lo, a_hi, c;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {l1i_as_cache, l1d_as_cache, direct_req_instr, direct_req_data} = 4'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'h0, ctap_pkg::RESP_OKAY);
    rd(8'h1C, 32'h0, ctap_pkg::RESP_SLVERR);
    wr(8'h20, 32'h1, ctap_pkg::RESP_SLVERR);
    wr(ctap_pkg::OFF_STATUS, 32'h1, ctap_pkg::RESP_SLVERR);
    $display("test registers done");
    // Tag write, read with reserved bits set, invalidate
    put(ctap_pkg::OFF_ICMD, ctap_pkg::CMD_ITAG_WR, 32'hA5A5_0001, 32'h1);
    get(ctap_pkg::OFF_ICMD, 32'h0C01_0378, 32'hA5A5_0001, 32'h0);
    put(ctap_pkg::OFF_ICMD, 32'h0C01_037A, 32'hA5A5_0000, 32'h2);
    get(ctap_pkg::OFF_ICMD, ctap_pkg::CMD_ITAG_RD, 32'hA5A5_0000, 32'h0);
    $display("test icache tag done");
    put(ctap_pkg::OFF_ICMD, ctap_pkg::CMD_IDATA_WR, 32'h1111_1111,
      32'h2222_2222);
    put(ctap_pkg::OFF_ICMD, 32'h0C01_0376, 32'h3333_3333, 32'h4444_4444);
    get(ctap_pkg::OFF_ICMD, ctap_pkg::CMD_IDATA_RD, 32'h3333_3333,
      32'h4444_4444);
    get(ctap_pkg::OFF_ICMD, 32'h0C01_0364, 32'h1111_1111, 32'h2222_2222);
    // Random locations and contents
    for (int i = 0; i < 6; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      c = icmd(lfsr_q[1:0], lfsr_q[6:2], lfsr_q[8:7], lfsr_q[10:9]);
      lfsr_q = lfsr_next(lfsr_q);
      a_lo = lfsr_q;
      lfsr_q = lfsr_next(lfsr_q);
      a_hi = lfsr_q;
      put(ctap_pkg::OFF_ICMD, c, a_lo, a_hi);
      get(ctap_pkg::OFF_ICMD, c & 32'hFFFF_FFFD, a_lo, a_hi);
    end
    $display("test icache data done");
    // Data cache word and tag; bit 14 set on the read is reserved
    put(ctap_pkg::OFF_DCMD, 32'h0400_04E7, a_hi, a_lo);
    get(ctap_pkg::OFF_DCMD, 32'h0400_44E5, a_hi, a_lo);
    put(ctap_pkg::OFF_DCMD, 32'h0400_04E3, 32'h5A5A_0001, 32'h7);
    get(ctap_pkg::OFF_DCMD, 32'h0400_04E1, 32'h5A5A_0001, 32'h0);
    // Same fields, bit 24 picks instruction SRAM instead
    put(ctap_pkg::OFF_DCMD, 32'h0403_4136, 32'hCAFE_0001, 32'hCAFE_0002);
    put(ctap_pkg::OFF_DCMD, 32'h0503_4136, a_lo, a_hi);
    get(ctap_pkg::OFF_DCMD, 32'h0503_4134, a_lo, a_hi);
    get(ctap_pkg::OFF_DCMD, 32'h0403_4134, 32'hCAFE_0001,
      32'hCAFE_0002);
    $display("test dcache and sram done");
    // Direct requests granted only when bank is not cache
    for (int i = 0; i < 4; i++) begin
      l1i_as_cache <= i[0];
      direct_req_instr <= i[1];
      l1d_as_cache <= i[1];
      direct_req_data <= i[0];
      repeat (2) @(posedge aclk);
      chk_bit(direct_grant_instr, i[1] & ~i[0]);
      chk_bit(direct_grant_data, i[0] & ~i[1]);
    end
    $display("test direct access done");
    complete_run();
  end
endmodule : tb_top
